// file: cmq_defs.svh
// Constants for the coarse mixer and quadrature correction stage.
// Assumes it is included by bare name wherever offsets or fields are needed.
`ifndef CMQ_DEFS_SVH
`define CMQ_DEFS_SVH

// Register word addresses.
`define CMQ_ADDR_CTRL    4'h0
`define CMQ_ADDR_GAIN    4'h1
`define CMQ_ADDR_PHASE   4'h2
`define CMQ_ADDR_OFFI    4'h3
`define CMQ_ADDR_OFFQ    4'h4
`define CMQ_ADDR_DLYI    4'h5
`define CMQ_ADDR_DLYQ    4'h6
`define CMQ_ADDR_STATUS  4'h7

// Field positions.
`define CMQ_CTRL_MIX_LSB 0
`define CMQ_CTRL_GAIN_B  4
`define CMQ_STAT_MIXCLIP 3
`define CMQ_STAT_QMCCLIP 4

// Select bits of the coarse mix field.
`define CMQ_SEL_EIGHTH   3
`define CMQ_SEL_QUARTER  2
`define CMQ_SEL_HALF     1
`define CMQ_SEL_NQUARTER 0

// Reset values.
`define CMQ_CTRL_RST     5'h00
`define CMQ_GAIN_RST     11'h400
`define CMQ_PHASE_RST    12'h000
`define CMQ_OFF_RST      13'h0000
`define CMQ_DLY_RST      8'h00

// Fixed eighth-rate trigonometric terms, unity at bit 16.
`define CMQ_TRIG_ONE     18'h10000
`define CMQ_TRIG_ROOT    18'h0B505

`endif

// file: cmq_pkg.sv
// Types shared by the coarse mixer and correction stage.
// Assumes nothing beyond a SystemVerilog compiler.
package cmq_pkg;

   // One signed sample of either channel.
   typedef logic signed [15:0] cmq_sample_t;

   // Which arithmetic the coarse mixer uses for the current select value.
   typedef enum logic [1:0] {
      CMQ_PATH_BYPASS,
      CMQ_PATH_SWAP,
      CMQ_PATH_MULT
   } cmq_path_t;

endpackage

// file: cmq_sat.sv
// Signed saturation of a wide result to one 16-bit sample.
// Assumes the input is a two's-complement value of width IW above 16.
`timescale 1ns/10ps
module cmq_sat #(
   parameter int IW = 35
) (
   // Wide value in.
   input  wire logic signed [IW-1:0] din,
   // Clamped sample and clamp flag out.
   output cmq_pkg::cmq_sample_t      dout,
   output logic                      clip
);

   // Clamping beats wrapping: a wrapped overflow would flip the sign at the DAC.
   always_comb begin
      if (din > IW'(32767)) begin
         dout = 16'sh7FFF;
         clip = 1'b1;
      end else if (din < -IW'(32768)) begin
         dout = 16'sh8000;
         clip = 1'b1;
      end else begin
         dout = din[15:0];
         clip = 1'b0;
      end
   end

endmodule

// file: cmq_delay.sv
// Per-channel sample delay line with a programmable depth.
// Assumes a sample arrives at most once a clock and the trim is held steady.
`timescale 1ns/10ps
module cmq_delay #(
   parameter int AW = 8
) (
   // Clock and reset.
   input  wire logic              mclk,
   input  wire logic              resetn,
   // Samples in.
   input  wire logic              in_valid,
   input  wire logic signed [15:0] din,
   // Delay in whole samples.
   input  wire logic [AW-1:0]     trim,
   // Samples out, registered.
   output logic                   out_valid,
   output logic signed [15:0]     dout
);

   logic signed [15:0] mem [2**AW];
   logic [AW-1:0]      wptr_q;

   // History store; it holds no reset, so a deep trim shows stale data at first.
   always_ff @(posedge mclk) begin
      if (in_valid) begin
         mem[wptr_q] <= din;
      end
   end

   // Write pointer advances with each accepted sample.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wptr_q <= '0;
      end else if (in_valid) begin
         wptr_q <= wptr_q + AW'(1);
      end
   end

   // Fixed one-cycle latency; the trim picks how far back the sample comes from.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         out_valid <= 1'b0;
         dout      <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            dout <= (trim == '0) ? din : mem[wptr_q - trim];
         end
      end
   end

endmodule

// file: cmq_top.sv
// Coarse complex mixer, quadrature correction and group delay trim.
// Assumes samples come one per clock at most and registers change between bursts.
//
// What this block does
// R01: Coarse mixer shifts spectrum only by signed multiples of fs/8.
// R02: Half and quarter shifts swap and negate, skip the multiplier and its gain.
// R03: Select zero passes I and Q unchanged in order.
// R04: Half-rate shift negates I and Q on every second sample.
// R05: Plus quarter shift follows I: +I,-Q,-I,+Q and Q: +Q,+I,-Q,-I.
// R06: Minus quarter shift follows I: +I,+Q,-I,-Q and Q: +Q,-I,-Q,+I.
// R07: Eighth shift uses the multiplier with fixed terms, combinable with others.
// R08: Select bits enable eighth, plus quarter, half and minus quarter shifters.
// R09: Selects 1000,1010,1100,1110 give +1/8,-3/8,+3/8,-1/8 of fs.
// R10: Multiplier output is halved when the gain option is clear.
// R11: Software uses full multiplier gain with care against clipping.
// R12: Software raises correction gain by 3 dB when halving is used.
// R13: Only bypass and half-rate keep each channel separable.
// R14: Path gain is 11-bit unsigned, point above bit 9, reset 1.0.
// R15: Phase term times Q is added into the I path.
// R16: Each channel adds its own 13-bit signed DC offset.
// R17: Offset and data add aligned at the least significant bit.
// R18: Each channel has its own 8-bit group delay trim.
// R19: Multiplier gain is one bit scaling by two to the bit minus one.
// R20: Offset and correction results saturate to signed 16 bits.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "cmq_defs.svh"
module cmq_top #(
   parameter int DW = 8
) (
   // Clock and reset.
   input  wire logic              mclk,
   input  wire logic              resetn,
   // Register port.
   input  wire logic [3:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   // Samples from the interpolation chain.
   input  wire logic              in_valid,
   input  wire logic signed [15:0] in_i,
   input  wire logic signed [15:0] in_q,
   // Samples to the converter cores.
   output logic                   out_valid,
   output logic signed [15:0]     out_i,
   output logic signed [15:0]     out_q
);

   // Configuration and status registers.
   logic [3:0]         cmix_q;
   logic               mixer_gain_q;
   logic [10:0]        gain_q;
   logic signed [11:0] phase_q;
   logic signed [12:0] inphase_dc_shift_q;
   logic signed [12:0] quadrature_dc_shift_q;
   logic [DW-1:0]      channel_delay_trim_q;
   logic [DW-1:0]      quad_delay_trim_q;
   logic [2:0]         sidx_q;
   logic               mixclip_q;
   logic               qmcclip_q;

   // Pipeline registers.
   cmq_pkg::cmq_sample_t mix_i_q;
   cmq_pkg::cmq_sample_t mix_q_q;
   logic                 mix_v_q;
   cmq_pkg::cmq_sample_t qmc_i_q;
   cmq_pkg::cmq_sample_t qmc_q_q;
   logic                 qmc_v_q;

   // Mixer intermediates.
   cmq_pkg::cmq_path_t   path;
   logic [1:0]           qsteps;
   logic [2:0]           estep;
   logic [2:0]           angle;
   logic signed [17:0]   cosv;
   logic signed [17:0]   sinv;
   logic signed [34:0]   prod_i;
   logic signed [34:0]   prod_q;
   logic signed [34:0]   mix_wi;
   logic signed [34:0]   mix_wq;
   cmq_pkg::cmq_sample_t mix_si;
   cmq_pkg::cmq_sample_t mix_sq;
   logic                 clip_mi;
   logic                 clip_mq;

   // Correction intermediates.
   logic signed [27:0]   gi_prod;
   logic signed [27:0]   gq_prod;
   logic signed [27:0]   ph_prod;
   logic signed [29:0]   qmc_wi;
   logic signed [29:0]   qmc_wq;
   cmq_pkg::cmq_sample_t qmc_si;
   cmq_pkg::cmq_sample_t qmc_sq;
   logic                 clip_ci;
   logic                 clip_cq;

   // Cosine of a multiple of 45 degrees; sine reuses it a quarter turn back.
   function automatic logic signed [17:0] cmq_cos(input logic [2:0] a);
      logic signed [17:0] r;
      r = '0;
      case (a)
         3'h0:    r = `CMQ_TRIG_ONE;
         3'h1:    r = `CMQ_TRIG_ROOT;
         3'h3:    r = -`CMQ_TRIG_ROOT;
         3'h4:    r = -`CMQ_TRIG_ONE;
         3'h5:    r = -`CMQ_TRIG_ROOT;
         3'h7:    r = `CMQ_TRIG_ROOT;
         default: r = '0;
      endcase
      return r;
   endfunction

   // Negation that clamps the most negative sample instead of wrapping.
   function automatic logic signed [15:0] cmq_neg(input logic signed [15:0] x);
      return (x == 16'sh8000) ? 16'sh7FFF : -x;
   endfunction

   // Rotation step per sample: quarter turns from bits 2..0, eighths from bit 3.
   always_comb begin
      qsteps = 2'h0;
      if (cmix_q[`CMQ_SEL_QUARTER]) begin
         qsteps = qsteps + 2'h1; // R08
      end
      if (cmix_q[`CMQ_SEL_HALF]) begin
         qsteps = qsteps + 2'h2; // R08
      end
      if (cmix_q[`CMQ_SEL_NQUARTER]) begin
         qsteps = qsteps + 2'h3; // R08
      end
      estep = {qsteps, cmix_q[`CMQ_SEL_EIGHTH]}; // R01 R09
      angle = 3'(estep * sidx_q);
      if (cmix_q == 4'h0) begin
         path = cmq_pkg::CMQ_PATH_BYPASS; // R03
      end else if (cmix_q[`CMQ_SEL_EIGHTH]) begin
         path = cmq_pkg::CMQ_PATH_MULT; // R07
      end else begin
         path = cmq_pkg::CMQ_PATH_SWAP; // R02
      end
   end

   // Fixed eighth-rate multiplier; the gain bit picks a shift of 16 or 17.
   always_comb begin
      cosv   = cmq_cos(angle);
      sinv   = cmq_cos(angle - 3'h2);
      // Operands are widened first so the product never keeps only the operand width.
      prod_i = 35'(in_i) * 35'(cosv) - 35'(in_q) * 35'(sinv); // R07
      prod_q = 35'(in_i) * 35'(sinv) + 35'(in_q) * 35'(cosv);
      case (path)
         cmq_pkg::CMQ_PATH_MULT: begin
            mix_wi = mixer_gain_q ? (prod_i >>> 16) : (prod_i >>> 17); // R10 R19
            mix_wq = mixer_gain_q ? (prod_q >>> 16) : (prod_q >>> 17); // R10 R19
         end
         cmq_pkg::CMQ_PATH_SWAP: begin
            // Quarter-turn rotation by swapping and negating; gain bit unused.
            case (angle[2:1])
               2'h0: begin
                  mix_wi = 35'(in_i);
                  mix_wq = 35'(in_q);
               end
               2'h1: begin
                  mix_wi = -35'(in_q); // R05
                  mix_wq = 35'(in_i);
               end
               2'h2: begin
                  mix_wi = -35'(in_i); // R04
                  mix_wq = -35'(in_q);
               end
               default: begin
                  mix_wi = 35'(in_q); // R06
                  mix_wq = -35'(in_i);
               end
            endcase
         end
         default: begin
            mix_wi = 35'(in_i); // R03 R13
            mix_wq = 35'(in_q);
         end
      endcase
   end

   cmq_sat #(.IW(35)) u_sat_mi (.din(mix_wi), .dout(mix_si), .clip(clip_mi));
   cmq_sat #(.IW(35)) u_sat_mq (.din(mix_wq), .dout(mix_sq), .clip(clip_mq));

   // Mixer output stage.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mix_i_q <= '0;
         mix_q_q <= '0;
         mix_v_q <= 1'b0;
      end else begin
         mix_v_q <= in_valid;
         if (in_valid) begin
            mix_i_q <= mix_si;
            mix_q_q <= mix_sq;
         end
      end
   end

   // Sample index restarts on a mode write so a new sequence begins at sample one.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sidx_q <= 3'h0;
      end else if (reg_wr && reg_addr == `CMQ_ADDR_CTRL) begin
         sidx_q <= 3'h0;
      end else if (in_valid) begin
         sidx_q <= sidx_q + 3'h1;
      end
   end

   // Gain, phase and offset arithmetic; the phase term is a skew, not a rotation.
   always_comb begin
      gi_prod = mix_i_q * $signed({1'b0, gain_q}); // R14
      gq_prod = mix_q_q * $signed({1'b0, gain_q}); // R14
      ph_prod = mix_q_q * phase_q; // R15
      qmc_wi  = 30'(gi_prod >>> 10) + 30'(ph_prod >>> 12) + 30'(inphase_dc_shift_q); // R16 R17
      qmc_wq  = 30'(gq_prod >>> 10) + 30'(quadrature_dc_shift_q); // R16 R17
   end

   cmq_sat #(.IW(30)) u_sat_ci (.din(qmc_wi), .dout(qmc_si), .clip(clip_ci)); // R20
   cmq_sat #(.IW(30)) u_sat_cq (.din(qmc_wq), .dout(qmc_sq), .clip(clip_cq)); // R20

   // Correction output stage.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qmc_i_q <= '0;
         qmc_q_q <= '0;
         qmc_v_q <= 1'b0;
      end else begin
         qmc_v_q <= mix_v_q;
         if (mix_v_q) begin
            qmc_i_q <= qmc_si;
            qmc_q_q <= qmc_sq;
         end
      end
   end

   // Independent trims let the two channels be skewed against each other.
   cmq_delay #(.AW(DW)) u_dly_i (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (qmc_v_q),
      .din       (qmc_i_q),
      .trim      (channel_delay_trim_q), // R18
      .out_valid (out_valid),
      .dout      (out_i)
   );
   cmq_delay #(.AW(DW)) u_dly_q (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (qmc_v_q),
      .din       (qmc_q_q),
      .trim      (quad_delay_trim_q), // R18
      .out_valid (),
      .dout      (out_q)
   );

   // Register writes.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         {mixer_gain_q, cmix_q} <= `CMQ_CTRL_RST;
         gain_q                 <= `CMQ_GAIN_RST; // R14
         phase_q                <= `CMQ_PHASE_RST;
         inphase_dc_shift_q     <= `CMQ_OFF_RST;
         quadrature_dc_shift_q  <= `CMQ_OFF_RST;
         channel_delay_trim_q   <= `CMQ_DLY_RST;
         quad_delay_trim_q      <= `CMQ_DLY_RST;
      end else if (reg_wr) begin
         if (reg_addr == `CMQ_ADDR_CTRL) begin
            cmix_q       <= reg_wdata[`CMQ_CTRL_MIX_LSB +: 4];
            mixer_gain_q <= reg_wdata[`CMQ_CTRL_GAIN_B]; // R19
         end else if (reg_addr == `CMQ_ADDR_GAIN) begin
            gain_q <= reg_wdata[10:0];
         end else if (reg_addr == `CMQ_ADDR_PHASE) begin
            phase_q <= reg_wdata[11:0];
         end else if (reg_addr == `CMQ_ADDR_OFFI) begin
            inphase_dc_shift_q <= reg_wdata[12:0];
         end else if (reg_addr == `CMQ_ADDR_OFFQ) begin
            quadrature_dc_shift_q <= reg_wdata[12:0];
         end else if (reg_addr == `CMQ_ADDR_DLYI) begin
            channel_delay_trim_q <= reg_wdata[DW-1:0];
         end else if (reg_addr == `CMQ_ADDR_DLYQ) begin
            quad_delay_trim_q <= reg_wdata[DW-1:0];
         end
      end
   end

   // Sticky clip flags; a new clip in the clearing cycle keeps the flag set.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mixclip_q <= 1'b0;
         qmcclip_q <= 1'b0;
      end else begin
         if (in_valid && (clip_mi || clip_mq)) begin
            mixclip_q <= 1'b1;
         end else if (reg_wr && reg_addr == `CMQ_ADDR_STATUS &&
                      reg_wdata[`CMQ_STAT_MIXCLIP]) begin
            mixclip_q <= 1'b0;
         end
         if (mix_v_q && (clip_ci || clip_cq)) begin
            qmcclip_q <= 1'b1;
         end else if (reg_wr && reg_addr == `CMQ_ADDR_STATUS &&
                      reg_wdata[`CMQ_STAT_QMCCLIP]) begin
            qmcclip_q <= 1'b0;
         end
      end
   end

   // Read data stand for one cycle only; unmapped addresses read zero.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else if (reg_addr == `CMQ_ADDR_CTRL) begin
         reg_rdata <= 16'({mixer_gain_q, cmix_q});
      end else if (reg_addr == `CMQ_ADDR_GAIN) begin
         reg_rdata <= 16'(gain_q);
      end else if (reg_addr == `CMQ_ADDR_PHASE) begin
         reg_rdata <= 16'($unsigned(phase_q));
      end else if (reg_addr == `CMQ_ADDR_OFFI) begin
         reg_rdata <= 16'($unsigned(inphase_dc_shift_q));
      end else if (reg_addr == `CMQ_ADDR_OFFQ) begin
         reg_rdata <= 16'($unsigned(quadrature_dc_shift_q));
      end else if (reg_addr == `CMQ_ADDR_DLYI) begin
         reg_rdata <= 16'(channel_delay_trim_q);
      end else if (reg_addr == `CMQ_ADDR_DLYQ) begin
         reg_rdata <= 16'(quad_delay_trim_q);
      end else if (reg_addr == `CMQ_ADDR_STATUS) begin
         reg_rdata <= 16'({qmcclip_q, mixclip_q, sidx_q});
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Checks on the datapath, all in the sample clock domain.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   property p_bypass;
      in_valid && cmix_q == 4'h0 |=> mix_i_q == $past(in_i) && mix_q_q == $past(in_q);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass altered a sample"); // R03

   property p_half;
      in_valid && cmix_q == 4'h2 && sidx_q[0]
      |=> mix_i_q == cmq_neg($past(in_i)) && mix_q_q == cmq_neg($past(in_q));
   endproperty
   a_half: assert property (p_half) else $error("half-rate did not negate"); // R04

   property p_quarter;
      in_valid && cmix_q == 4'h4 && sidx_q[1:0] == 2'h1
      |=> mix_i_q == cmq_neg($past(in_q)) && mix_q_q == $past(in_i);
   endproperty
   a_quarter: assert property (p_quarter) else $error("plus quarter sample two wrong"); // R05

   property p_nquarter;
      in_valid && cmix_q == 4'h1 && sidx_q[1:0] == 2'h3
      |=> mix_i_q == cmq_neg($past(in_q)) && mix_q_q == $past(in_i);
   endproperty
   a_nquarter: assert property (p_nquarter) else $error("minus quarter sample four wrong"); // R06

   property p_halving;
      in_valid && cmix_q == 4'h8 && sidx_q == 3'h0 && !mixer_gain_q
      |=> mix_i_q == ($past(in_i) >>> 1);
   endproperty
   a_halving: assert property (p_halving) else $error("multiplier not halved"); // R10

   property p_gain_reset;
      !$past(resetn) |-> gain_q == `CMQ_GAIN_RST;
   endproperty
   a_gain_reset: assert property (p_gain_reset) else $error("gain not unity after reset"); // R14

   property p_offset;
      mix_v_q && gain_q == `CMQ_GAIN_RST && phase_q == 12'sh000 &&
      mix_i_q > -16'sh7000 && mix_i_q < 16'sh7000
      |=> qmc_i_q == $past(mix_i_q) + 16'($past(inphase_dc_shift_q));
   endproperty
   a_offset: assert property (p_offset) else $error("offset sum wrong"); // R16

   property p_saturate;
      mix_v_q && mix_i_q == 16'sh7FFF && gain_q == 11'h7FF && phase_q == 12'sh000 &&
      !inphase_dc_shift_q[12] |=> qmc_i_q == 16'sh7FFF;
   endproperty
   a_saturate: assert property (p_saturate) else $error("correction wrapped"); // R20

   property p_trim_zero;
      qmc_v_q && channel_delay_trim_q == '0 |=> out_valid && out_i == $past(qmc_i_q);
   endproperty
   a_trim_zero: assert property (p_trim_zero) else $error("zero trim delayed data"); // R18

   c_eighth:  cover property (in_valid && cmix_q == 4'hE);
   c_quarter: cover property (in_valid && cmix_q == 4'h4 ##1 in_valid [*3]);
   c_clip:    cover property (mix_v_q && clip_ci);

endmodule

// file: cmq_far_end.sv
// Partner model: the upstream sample source and the downstream converter capture.
// Assumes one clock shared with the block under test and no back-pressure.
`timescale 1ns/10ps
module cmq_far_end (
   // Clock.
   input  wire logic               mclk,
   // Samples towards the block.
   output logic                    in_valid,
   output logic signed [15:0]      in_i,
   output logic signed [15:0]      in_q,
   // Samples from the block.
   input  wire logic               out_valid,
   input  wire logic signed [15:0] out_i,
   input  wire logic signed [15:0] out_q
);
   logic signed [15:0] pend_i[$];
   logic signed [15:0] pend_q[$];
   logic signed [15:0] got_i[$];
   logic signed [15:0] got_q[$];

   // Lines start quiet so nothing is mistaken for a sample before the first burst.
   initial begin
      in_valid = 1'b0;
      in_i     = 16'h0000;
      in_q     = 16'h0000;
   end

   // Queued samples leave back to back; idle lines flip so a stale value never looks fresh.
   always @(posedge mclk) begin
      if (pend_i.size() > 0) begin
         in_valid <= 1'b1;
         in_i     <= pend_i.pop_front();
         in_q     <= pend_q.pop_front();
      end else begin
         in_valid <= 1'b0;
         in_i     <= ~in_i;
         in_q     <= ~in_q;
      end
   end

   // The converter side never stalls, so every valid sample is kept.
   always @(posedge mclk) begin
      if (out_valid === 1'b1) begin
         got_i.push_back(out_i);
         got_q.push_back(out_q);
      end
   end

   // Queues one complex sample for sending.
   task automatic put(input logic signed [15:0] i, input logic signed [15:0] q);
      pend_i.push_back(i);
      pend_q.push_back(q);
   endtask
endmodule

// file: cmq_top_test.sv
// Self-checking bench for the coarse mixer and correction stage.
// Assumes the design files and the partner model are compiled first.
`timescale 1ns/10ps
`include "cmq_defs.svh"
module cmq_top_test;
   localparam logic [15:0] RST_V [0:8] = '{16'h0000, 16'h0400, 16'h0000, 16'h0000,
                                           16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [4:0]  MODE_SEL [0:3] = '{5'h00, 5'h12, 5'h14, 5'h11};
   localparam int          MODE_STEP [0:3] = '{0, 2, 1, 3};
   localparam logic [4:0]  EIGHT_SEL [0:3] = '{5'h18, 5'h1A, 5'h1C, 5'h1E};
   localparam logic [15:0] EIGHT_I [0:3] = '{16'h0000, 16'h0000, 16'hFA79, 16'h0586};
   localparam logic [15:0] EIGHT_Q [0:3] = '{16'h0586, 16'hFA79, 16'h0000, 16'h0000};

   logic               mclk;
   logic               resetn;
   logic [3:0]         reg_addr;
   logic [15:0]        reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   logic [15:0]        reg_rdata;
   logic               in_valid;
   logic signed [15:0] in_i;
   logic signed [15:0] in_q;
   logic               out_valid;
   logic signed [15:0] out_i;
   logic signed [15:0] out_q;
   logic [15:0]        rv;
   logic [31:0]        e;
   int                 mismatches;
   int                 checks_done;
   int                 cycles;

   cmq_top #(.DW(8)) dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
      .out_i(out_i), .out_q(out_q));
   cmq_far_end far_u (.mclk(mclk), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
      .out_valid(out_valid), .out_i(out_i), .out_q(out_q));

   // A 25 ns clock.
   initial begin
      mclk = 1'b0;
   end
   always #12.5 mclk = ~mclk;

   // A hang is cut short well past the few hundred cycles the tests need.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("Checks made %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Compares one seen value with its expectation.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   // One-cycle register read; the data stand only in the next cycle.
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Waits a bounded time for n captured samples.
   task automatic wait_out(input int n);
      int w;
      for (w = 0; w < 60 && far_u.got_i.size() < n; w++) begin
         @(posedge mclk);
      end
      #1;
      chk(16'(far_u.got_i.size()), 16'(n));
   endtask

   // Compares the oldest captured sample.
   task automatic take(input logic [15:0] ei, input logic [15:0] eq);
      chk(far_u.got_i.pop_front(), ei);
      chk(far_u.got_q.pop_front(), eq);
   endtask

   // Rotation by r quarter turns, the effect of swapping and negating.
   function automatic logic [31:0] rot(input logic signed [15:0] i, input logic signed [15:0] q,
                                       input int r);
      case (r % 4)
         0: return {i, q};
         1: return {-q, i};
         2: return {-i, -q};
         default: return {q, -i};
      endcase
   endfunction

   // Main sequence.
   initial begin
      reg_addr    = 4'h0;
      reg_wdata   = 16'h0000;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      resetn      = 1'b0;
      mismatches  = 0;
      checks_done = 0;
      cycles      = 0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         rd(4'(k), rv);
         chk(rv, RST_V[k]);
      end
      wr(4'h8, 16'hFFFF);
      rd(4'h8, rv);
      chk(rv, 16'h0000);
      // Bypass, half and both quarter shifts, with the gain bit set in the three shifts, where it must not matter.
      for (int m = 0; m < 4; m++) begin
         wr(`CMQ_ADDR_CTRL, {11'h000, MODE_SEL[m]});
         for (int k = 0; k < 8; k++) begin
            far_u.put(16'h03E8 + 16'(k), 16'hF830 - 16'(k));
         end
         wait_out(8);
         for (int k = 0; k < 8; k++) begin
            e = rot(16'h03E8 + 16'(k), 16'hF830 - 16'(k), MODE_STEP[m] * k);
            take(e[31:16], e[15:0]);
         end
      end
      // Eighth-rate combinations at full multiplier gain; small inputs keep clear of clipping.
      for (int m = 0; m < 4; m++) begin
         wr(`CMQ_ADDR_CTRL, {11'h000, EIGHT_SEL[m]});
         far_u.put(16'h03E8, 16'h03E8);
         far_u.put(16'h03E8, 16'h03E8);
         wait_out(2);
         take(16'h03E8, 16'h03E8);
         take(EIGHT_I[m], EIGHT_Q[m]);
      end
      // Halved multiplier, made up by about 3 dB of correction gain.
      wr(`CMQ_ADDR_GAIN, 16'h05A8);
      wr(`CMQ_ADDR_CTRL, 16'h0008);
      far_u.put(16'h03E8, 16'h03E8);
      far_u.put(16'h03E8, 16'h03E8);
      wait_out(2);
      take(16'h02C3, 16'h02C3);
      take(16'h0000, 16'h03E7);
      // Gain, phase and offsets together in bypass.
      wr(`CMQ_ADDR_CTRL, 16'h0000);
      wr(`CMQ_ADDR_GAIN, 16'h0600);
      wr(`CMQ_ADDR_PHASE, 16'h0400);
      wr(`CMQ_ADDR_OFFI, 16'h1FFB);
      wr(`CMQ_ADDR_OFFQ, 16'h0007);
      far_u.put(16'h03E8, 16'h07D0);
      wait_out(1);
      take(16'h07CB, 16'h0BBF);
      // Largest gain drives both channels past the sample range.
      wr(`CMQ_ADDR_GAIN, 16'h07FF);
      wr(`CMQ_ADDR_PHASE, 16'h0000);
      wr(`CMQ_ADDR_OFFI, 16'h0000);
      wr(`CMQ_ADDR_OFFQ, 16'h0000);
      far_u.put(16'h7FFF, 16'h8AD0);
      wait_out(1);
      take(16'h7FFF, 16'h8000);
      // Two samples since the last mode write; only the correction stage clipped.
      rd(`CMQ_ADDR_STATUS, rv);
      chk(rv, 16'h0012);
      wr(`CMQ_ADDR_STATUS, 16'h0010);
      rd(`CMQ_ADDR_STATUS, rv);
      chk(rv, 16'h0002);
      // Independent delay trims: I two samples late, Q one, with a small I offset.
      wr(`CMQ_ADDR_GAIN, 16'h0400);
      wr(`CMQ_ADDR_OFFI, 16'h0003);
      wr(`CMQ_ADDR_DLYI, 16'h0002);
      wr(`CMQ_ADDR_DLYQ, 16'h0001);
      for (int k = 0; k < 6; k++) begin
         far_u.put(16'h0064 + 16'(k), 16'h00C8 + 16'(k));
      end
      wait_out(6);
      for (int k = 0; k < 6; k++) begin
         rv = far_u.got_i.pop_front();
         if (k >= 2) begin
            chk(rv, 16'h0065 + 16'(k));
         end
         rv = far_u.got_q.pop_front();
         if (k >= 1) begin
            chk(rv, 16'h00C7 + 16'(k));
         end
      end
      conclude();
   end
endmodule
